// [logic/plc_loop_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "plc_params.svh"

module plc_loop_regs (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // oscillator band from autocalibration
  input  wire logic [4:0]  osc_band_readback,
  input  wire logic        osc_band_load,
  // phase detector controls
  output logic             phase_detector_on,
  output logic             pulse_width_stretch,
  // loop filter controls
  output logic      [3:0]  filter_cap_select,
  output logic             filter_bias_on,
  output logic             filter_amp_on,
  output logic      [8:0]  filter_cap_half_pf
);

  // ----------------------------------------------------------------
  // reset image of the state
  // ----------------------------------------------------------------
  localparam logic [7:0] PHASE_RST  = `PLC_PHASE_RST;
  localparam logic [7:0] FILTER_RST = `PLC_FILTER_RST;
  localparam logic [4:0] BAND_RST   = `PLC_BAND_RST;
  localparam logic [7:0] SCR_RST    = `PLC_SCRATCH_RST;

  localparam plc_pkg::plc_state_t STATE_RST = '{
    pd_on:      PHASE_RST[`PLC_PD_ON_BIT],
    pd_stretch: PHASE_RST[`PLC_PD_STRETCH],
    cap_sel:    FILTER_RST[`PLC_CAP_MSB:`PLC_CAP_LSB],
    bias_on:    FILTER_RST[`PLC_BIAS_BIT],
    amp_on:     FILTER_RST[`PLC_AMP_BIT],
    band:       BAND_RST,
    scratch_b:  SCR_RST,
    scratch_c:  SCR_RST,
    wr_pend:    1'b0,
    wr_sel:     plc_pkg::PLC_SEL_NONE,
    rdata:      32'h0000_0000,
    ready:      1'b1,
    resp:       1'b0,
    cap_hpf:    9'h06E                                              // 55 pF, matches code 4
  };

  // ----------------------------------------------------------------
  // state and next state
  // ----------------------------------------------------------------
  plc_pkg::plc_state_t cur;
  plc_pkg::plc_state_t next_cur;

  // ----------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------
  logic              take;
  plc_pkg::plc_sel_t take_sel;

  plc_ahb_decode u_decode (
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hsize  (hsize),
    .hready (hready),
    .take   (take),
    .sel    (take_sel)
  );

  // ----------------------------------------------------------------
  // capacitance value for the current code
  // ----------------------------------------------------------------
  logic [8:0] cap_hpf_now;

  plc_cap_scale u_cap (
    .code    (cur.cap_sel),
    .half_pf (cap_hpf_now)
  );

  // ----------------------------------------------------------------
  // read images of each register
  // ----------------------------------------------------------------
  function automatic logic [7:0] phase_image(input plc_pkg::plc_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`PLC_PD_ON_BIT]  = s.pd_on;
    v[`PLC_PD_STRETCH] = s.pd_stretch;
    return v;
  endfunction : phase_image

  function automatic logic [7:0] filter_image(input plc_pkg::plc_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`PLC_CAP_MSB:`PLC_CAP_LSB] = s.cap_sel;
    v[`PLC_BIAS_BIT]             = s.bias_on;
    v[`PLC_AMP_BIT]              = s.amp_on;
    return v;
  endfunction : filter_image

  function automatic logic [7:0] band_image(input plc_pkg::plc_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`PLC_BAND_MSB:0] = s.band;
    return v;
  endfunction : band_image

  // byte wide register view of any select
  function automatic logic [7:0] read_image(
    input plc_pkg::plc_state_t s,
    input plc_pkg::plc_sel_t   sel
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (sel)
      plc_pkg::PLC_SEL_PHASE:     v = phase_image(s);
      plc_pkg::PLC_SEL_FILTER:    v = filter_image(s);
      plc_pkg::PLC_SEL_BAND:      v = band_image(s);
      plc_pkg::PLC_SEL_SCRATCH_B: v = s.scratch_b;
      plc_pkg::PLC_SEL_SCRATCH_C: v = s.scratch_c;
      plc_pkg::PLC_SEL_NONE:      v = 8'h00;
      default:                    v = 8'h00;
    endcase
    return v;
  endfunction : read_image

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // order matters: the pending write lands first, then the band
  // capture, then the read image, so a read issued right behind a
  // write to the same register already sees the new value
  always_comb begin
    next_cur = cur;

    // data phase of a write: only the live fields take the data;
    // reserved bits in hwdata are dropped here, the host is expected
    // to send them as zero
    if (cur.wr_pend) begin
      unique case (cur.wr_sel)
        plc_pkg::PLC_SEL_PHASE: begin
          next_cur.pd_stretch = hwdata[`PLC_PD_STRETCH];
          next_cur.pd_on      = hwdata[`PLC_PD_ON_BIT];
        end
        plc_pkg::PLC_SEL_FILTER: begin
          next_cur.cap_sel = hwdata[`PLC_CAP_MSB:`PLC_CAP_LSB];
          next_cur.bias_on = hwdata[`PLC_BIAS_BIT];
          next_cur.amp_on  = hwdata[`PLC_AMP_BIT];
        end
        plc_pkg::PLC_SEL_SCRATCH_B: begin
          next_cur.scratch_b = hwdata[7:0];
        end
        plc_pkg::PLC_SEL_SCRATCH_C: begin
          next_cur.scratch_c = hwdata[7:0];
        end
        plc_pkg::PLC_SEL_BAND: begin
          next_cur.band = cur.band;
        end
        plc_pkg::PLC_SEL_NONE: begin
          next_cur.band = cur.band;
        end
        default: begin
          next_cur.band = cur.band;
        end
      endcase
    end

    // band register changes only by the calibration strobe
    if (osc_band_load) begin
      next_cur.band = osc_band_readback;
    end

    // address phase bookkeeping; a write waits for its data phase
    next_cur.wr_pend = take && hwrite;
    next_cur.wr_sel  = take ? take_sel : plc_pkg::PLC_SEL_NONE;

    // read data is loaded at the address edge so that it stands for
    // the whole data phase; unmapped addresses read as zero
    if (take && !hwrite) begin
      next_cur.rdata = {24'h00_0000, read_image(next_cur, take_sel)};
    end else begin
      next_cur.rdata = 32'h0000_0000;
    end

    // zero wait states, never an error
    next_cur.ready = 1'b1;
    next_cur.resp  = 1'b0;

    // capacitance readout trails the code by one cycle
    next_cur.cap_hpf = cap_hpf_now;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cur <= STATE_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------
  assign hrdata    = cur.rdata;
  assign hreadyout = cur.ready;
  assign hresp     = cur.resp;

  // ----------------------------------------------------------------
  // control outputs, straight from the state register
  // ----------------------------------------------------------------
  // scratch bytes drive nothing outside the register file
  assign phase_detector_on   = cur.pd_on;
  assign pulse_width_stretch = cur.pd_stretch;
  assign filter_cap_select   = cur.cap_sel;
  assign filter_bias_on      = cur.bias_on;
  assign filter_amp_on       = cur.amp_on;
  assign filter_cap_half_pf  = cur.cap_hpf;

endmodule : plc_loop_regs
`default_nettype wire

// [logic/plc_params.svh]
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

// ----------------------------------------------------------------
// register indexes; byte address is four times the index
// ----------------------------------------------------------------
`define PLC_IDX_PHASE     10'h026
`define PLC_IDX_FILTER    10'h027
`define PLC_IDX_BAND      10'h028
`define PLC_IDX_SCRATCH_B 10'h0FE
`define PLC_IDX_SCRATCH_C 10'h0FF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PLC_PD_ON_BIT     0
`define PLC_PD_STRETCH    1
`define PLC_CAP_LSB       2
`define PLC_CAP_MSB       5
`define PLC_AMP_BIT       0
`define PLC_BIAS_BIT      1
`define PLC_BAND_MSB      4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PLC_PHASE_RST     8'h01
`define PLC_FILTER_RST    8'h13
`define PLC_BAND_RST      5'h00
`define PLC_SCRATCH_RST   8'h00

// ----------------------------------------------------------------
// capacitance scale, in half picofarads
// ----------------------------------------------------------------
`define PLC_CAP_BASE_HPF  9'h00A
`define PLC_CAP_STEP_HPF  9'h019

`endif

// [logic/plc_pkg.sv]
package plc_pkg;

  // ----------------------------------------------------------------
  // register select, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    PLC_SEL_NONE      = 6'b00_0001,
    PLC_SEL_PHASE     = 6'b00_0010,
    PLC_SEL_FILTER    = 6'b00_0100,
    PLC_SEL_BAND      = 6'b00_1000,
    PLC_SEL_SCRATCH_B = 6'b01_0000,
    PLC_SEL_SCRATCH_C = 6'b10_0000
  } plc_sel_t;

  // ----------------------------------------------------------------
  // whole state of the register slice
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        pd_on;
    logic        pd_stretch;
    logic [3:0]  cap_sel;
    logic        bias_on;
    logic        amp_on;
    logic [4:0]  band;
    logic [7:0]  scratch_b;
    logic [7:0]  scratch_c;
    logic        wr_pend;
    plc_sel_t    wr_sel;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
    logic [8:0]  cap_hpf;
  } plc_state_t;

endpackage : plc_pkg

// [logic/plc_ahb_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "plc_params.svh"

module plc_ahb_decode (
  // address phase
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  // decoded request
  output logic             take,
  output plc_pkg::plc_sel_t sel
);

  logic [9:0] index;

  // low twelve bits decode; upper bits alias
  assign index = haddr[11:2];
  assign take  = hsel && htrans[1] && hready;

  // sub-word and misaligned accesses land on no register
  always_comb begin
    sel = plc_pkg::PLC_SEL_NONE;
    if (hsize == 3'h2 && haddr[1:0] == 2'h0) begin
      unique case (index)
        `PLC_IDX_PHASE:     sel = plc_pkg::PLC_SEL_PHASE;
        `PLC_IDX_FILTER:    sel = plc_pkg::PLC_SEL_FILTER;
        `PLC_IDX_BAND:      sel = plc_pkg::PLC_SEL_BAND;
        `PLC_IDX_SCRATCH_B: sel = plc_pkg::PLC_SEL_SCRATCH_B;
        `PLC_IDX_SCRATCH_C: sel = plc_pkg::PLC_SEL_SCRATCH_C;
        default:            sel = plc_pkg::PLC_SEL_NONE;
      endcase
    end
  end

endmodule : plc_ahb_decode
`default_nettype wire

// [logic/plc_cap_scale.sv]
`timescale 1ns/1ps
`default_nettype none
`include "plc_params.svh"

module plc_cap_scale (
  // selected code
  input  wire logic [3:0] code,
  // capacitance in half picofarads
  output logic      [8:0] half_pf
);

  logic [8:0] product;

  // equal steps from the base value, 10 to 385 half pF; 25 * 15 fits nine bits
  assign product = `PLC_CAP_STEP_HPF * {5'h00, code};
  assign half_pf = `PLC_CAP_BASE_HPF + product[8:0];

endmodule : plc_cap_scale
`default_nettype wire

// [test/plc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "plc_params.svh"

module plc_host_model (
  // clock
  input  wire logic        clk_sys,
  // master requests
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  // slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // bus idle at time zero
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;

  // one word; each phase held until hready is sampled high
  task automatic xfer(input logic w, input logic [9:0] idx,
                      input logic [31:0] wd, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~haddr;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~wd; // released data never keeps its last value
  endtask : xfer

  // reserved bits go out as zero unless a test breaks that on purpose
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic raw);
    logic [31:0] m;
    m = 32'h0000_00FF;
    if (!raw && idx == `PLC_IDX_PHASE) m = 32'h0000_0003;
    if (!raw && idx == `PLC_IDX_FILTER) m = 32'h0000_003F;
    xfer(1'b1, idx, {24'h00_0000, d} & m, m);
  endtask : wr

  task automatic rd(input logic [9:0] idx, output logic [31:0] q);
    xfer(1'b0, idx, 32'h0000_0000, q);
  endtask : rd
endmodule : plc_host_model
`default_nettype wire

// [test/plc_loop_regs_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "plc_params.svh"

module plc_loop_regs_chk (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // loop controls
  input wire logic        phase_detector_on,
  input wire logic        pulse_width_stretch,
  input wire logic [3:0]  filter_cap_select,
  input wire logic        filter_bias_on,
  input wire logic        filter_amp_on,
  input wire logic [8:0]  filter_cap_half_pf
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // aligned word transfers taken in the address phase
  wire logic       take = hsel && htrans[1] && hready && hsize == 3'b010 && haddr[1:0] == 2'b00;
  wire logic [9:0] idx  = haddr[11:2];
  wire logic       wr   = take && hwrite;
  wire logic       rd   = take && !hwrite;

  AST_PD_RESET: assert property ($rose(reset_n) |-> phase_detector_on && !pulse_width_stretch)
    else $error("phase controls wrong after reset");
  AST_FILT_RESET: assert property ($rose(reset_n) |-> filter_cap_select == 4'h4 &&
    filter_bias_on && filter_amp_on) else $error("filter controls wrong after reset");
  AST_PD_WRITE: assert property (wr && idx == `PLC_IDX_PHASE ##1 1'b1 |=>
    {pulse_width_stretch, phase_detector_on} == $past(hwdata[1:0]))
    else $error("phase write not applied");
  AST_FILT_WRITE: assert property (wr && idx == `PLC_IDX_FILTER ##1 1'b1 |=>
    {filter_cap_select, filter_bias_on, filter_amp_on} == $past(hwdata[5:0]))
    else $error("filter write not applied");
  AST_CAP_SCALE: assert property ($past(reset_n) && $past(reset_n, 2) |->
    filter_cap_half_pf == 9'h00A + 9'h019 * $past(filter_cap_select))
    else $error("capacitance value does not follow code");
  AST_SCR_INERT: assert property (wr && idx >= `PLC_IDX_SCRATCH_B ##1 1'b1 |=>
    $stable({phase_detector_on, pulse_width_stretch, filter_cap_select, filter_bias_on,
    filter_amp_on})) else $error("scratch write moved a control");
  AST_FILT_READ: assert property (rd && idx == `PLC_IDX_FILTER |=>
    hrdata == {26'h000_0000, filter_cap_select, filter_bias_on, filter_amp_on})
    else $error("filter read mismatch");
  AST_BAND_READ: assert property (rd && idx == `PLC_IDX_BAND |=>
    hrdata[31:5] == 27'h000_0000) else $error("band upper bits not zero");
endmodule : plc_loop_regs_chk

bind plc_loop_regs plc_loop_regs_chk chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .phase_detector_on(phase_detector_on), .pulse_width_stretch(pulse_width_stretch),
  .filter_cap_select(filter_cap_select), .filter_bias_on(filter_bias_on),
  .filter_amp_on(filter_amp_on), .filter_cap_half_pf(filter_cap_half_pf));
`default_nettype wire

// [test/pll_loop_config_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "plc_params.svh"

module pll_loop_config_regs_bench;
  logic        clk_sys = 1'b0;
  logic        reset_n, osc_band_load, hsel, hwrite, hreadyout, hresp;
  logic        phase_detector_on, pulse_width_stretch, filter_bias_on, filter_amp_on;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  filter_cap_select;
  logic [4:0]  osc_band_readback;
  logic [8:0]  filter_cap_half_pf;
  logic [31:0] haddr, hwdata, hrdata;
  int          fail_count = 0;
  int          compares = 0;

  // 40 MHz
  always #12.5 clk_sys = ~clk_sys;

  plc_host_model host_u (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  plc_loop_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .osc_band_readback(osc_band_readback), .osc_band_load(osc_band_load),
    .phase_detector_on(phase_detector_on), .pulse_width_stretch(pulse_width_stretch),
    .filter_cap_select(filter_cap_select), .filter_bias_on(filter_bias_on),
    .filter_amp_on(filter_amp_on), .filter_cap_half_pf(filter_cap_half_pf));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // read a register and compare it; hresp must stay okay
  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    host_u.rd(idx, q);
    chk(q, exp);
    chk(32'(hresp), 32'h0000_0000);
  endtask : rdchk

  task automatic t_reset;
    rdchk(`PLC_IDX_PHASE, 32'h0000_0001);
    rdchk(`PLC_IDX_FILTER, 32'h0000_0013);
    rdchk(`PLC_IDX_BAND, 32'h0000_0000);
    rdchk(`PLC_IDX_SCRATCH_B, 32'h0000_0000);
    rdchk(`PLC_IDX_SCRATCH_C, 32'h0000_0000);
    $display("reset values done");
  endtask : t_reset

  task automatic t_phase;
    host_u.wr(`PLC_IDX_PHASE, 8'h02, 1'b0);
    rdchk(`PLC_IDX_PHASE, 32'h0000_0002);
    chk(32'({pulse_width_stretch, phase_detector_on}), 32'h0000_0002);
    host_u.wr(`PLC_IDX_PHASE, 8'hFD, 1'b1);
    rdchk(`PLC_IDX_PHASE, 32'h0000_0001);
    $display("phase detector done");
  endtask : t_phase

  // every capacitance code, bias and amp patterns riding on the low bits
  task automatic t_filter;
    logic [7:0] d;
    for (int c = 0; c < 16; c++) begin
      d = {2'b00, c[3:0], c[1:0]};
      host_u.wr(`PLC_IDX_FILTER, d, 1'b0);
      rdchk(`PLC_IDX_FILTER, 32'(d));
      chk(32'({filter_cap_select, filter_bias_on, filter_amp_on}), 32'(d));
      chk(32'(filter_cap_half_pf), 32'(10 + 25 * c));
    end
    host_u.wr(`PLC_IDX_FILTER, 8'hD3, 1'b1);
    rdchk(`PLC_IDX_FILTER, 32'h0000_0013);
    $display("loop filter done");
  endtask : t_filter

  task automatic t_band;
    osc_band_readback <= 5'h15;
    osc_band_load     <= 1'b1;
    @(posedge clk_sys);
    osc_band_load     <= 1'b0;
    osc_band_readback <= 5'h0A; // must not be captured without the strobe
    rdchk(`PLC_IDX_BAND, 32'h0000_0015);
    host_u.wr(`PLC_IDX_BAND, 8'hFF, 1'b1);
    rdchk(`PLC_IDX_BAND, 32'h0000_0015);
    $display("band readback done");
  endtask : t_band

  task automatic t_scratch;
    host_u.wr(`PLC_IDX_SCRATCH_B, 8'hA5, 1'b0);
    host_u.wr(`PLC_IDX_SCRATCH_C, 8'h5A, 1'b0);
    rdchk(`PLC_IDX_SCRATCH_B, 32'h0000_00A5);
    rdchk(`PLC_IDX_SCRATCH_C, 32'h0000_005A);
    chk(32'({phase_detector_on, filter_cap_select}), 32'h0000_0014);
    rdchk(10'h029, 32'h0000_0000);
    $display("scratch done");
  endtask : t_scratch

  task automatic stop_test;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // main sequence; first request only after reset is seen released
  initial begin
    {reset_n, osc_band_load, osc_band_readback} = '0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_phase();
    t_filter();
    t_band();
    t_scratch();
    stop_test();
  end

  // whole run needs about 110 cycles; 3000, over twenty-five times that, means a hang
  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : pll_loop_config_regs_bench
`default_nettype wire
